// ---- logic/sscrc_pkg.sv ----
// sscrc_pkg: constants and types shared by the sync/check output block.
// assumes: one 200 MHz system clock; pixel words are 10 bits wide.
package sscrc_pkg;

   localparam int PIX_W = 10;
   localparam int KERN_PIX = 8;
   localparam int LANES = 4;
   localparam int FIFO_DEPTH = 8;

   // kernel word layout
   localparam int F_FIRST = 80;
   localparam int F_LAST = 81;
   localparam int F_FBEG = 82;
   localparam int F_FEND = 83;
   localparam int F_BLACK = 84;
   localparam int F_WIN_LSB = 85;
   localparam int WORD_W = 93;

   // register indices
   localparam logic [7:0] ADDR_TRAIN = 8'h82;
   localparam logic [7:0] ADDR_SYNC = 8'h83;
   localparam logic [7:0] ADDR_BLACK = 8'h84;
   localparam logic [7:0] ADDR_IMAGE = 8'h85;
   localparam logic [7:0] ADDR_CHECK = 8'h86;
   localparam logic [7:0] ADDR_STRAIN = 8'h87;

   // reset values (10-bit form)
   localparam logic [9:0] RST_TRAIN = 10'h3a6;
   localparam logic [9:0] RST_SYNC = 10'h02a;
   localparam logic [9:0] RST_BLACK = 10'h015;
   localparam logic [9:0] RST_IMAGE = 10'h035;
   localparam logic [9:0] RST_CHECK = 10'h059;
   localparam logic [9:0] RST_STRAIN = 10'h3a6;

   // sync word type field
   localparam logic [2:0] frame_begin_mark = 3'h5;
   localparam logic [2:0] frame_finish_mark = 3'h6;
   localparam logic [2:0] line_begin_mark = 3'h1;
   localparam logic [2:0] line_finish_mark = 3'h2;

   // check polynomials without the top term
   localparam logic [9:0] CRC10_POLY = 10'h24f;
   localparam logic [7:0] CRC8_POLY = 8'h4d;
   localparam logic [9:0] CRC10_ONES = 10'h3ff;
   localparam logic [9:0] CRC8_ONES = 10'h0ff;

   typedef enum logic [2:0] {
      ST_IDLE, ST_BEGIN_MARK, ST_BEGIN_ID, ST_PIX, ST_END_MARK, ST_END_ID, ST_CHECK
   } sscrc_state_type;

endpackage

// ---- logic/sscrc_fifo.sv ----
// sscrc_fifo: kernel buffer with valid/ready on both sides.
// assumes: single clock, synchronous active-high reset.
`timescale 1ns/100ps
module sscrc_fifo #(
   parameter int WIDTH = 93,
   parameter int DEPTH = 8
) (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset
   input wire logic [WIDTH-1:0] in_data, // word to store
   input wire logic in_valid, // writer offers a word
   output logic in_ready, // room left (registered)
   output logic [WIDTH-1:0] out_data, // oldest word
   output logic out_valid, // oldest word present (registered)
   input wire logic out_ready // reader takes the word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr;
   logic [AW:0] count;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         // pointers wrap only because DEPTH is a power of two
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         count <= next_count;
         in_ready <= (next_count != DEPTH[AW:0]);
         out_valid <= (next_count != '0);
      end
   end
endmodule

// ---- logic/sscrc_crc.sv ----
// sscrc_crc: per-line check generator for one output channel.
// assumes: init and en never in the same cycle; en marks one data word.
`timescale 1ns/100ps
module sscrc_crc (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset
   input wire logic init, // reseed at line start
   input wire logic en, // fold in one data word
   input wire logic seed_one, // seed with ones when high
   input wire logic mode8, // 8-bit polynomial
   input wire logic [9:0] din, // data word (low 8 bits in 8-bit mode)
   output logic [9:0] crc // running check value
);
   import sscrc_pkg::*;

   function automatic logic [9:0] crc_step(logic [9:0] c, logic [9:0] d, logic m8);
      logic [9:0] r;
      logic fb;
      r = c;
      fb = 1'b0;
      if (m8) begin
         for (int i = 7; i >= 0; i--) begin
            fb = r[7] ^ d[i];
            r[7:0] = {r[6:0], 1'b0} ^ (fb ? CRC8_POLY : 8'h00);
         end
         r[9:8] = 2'b00;
      end else begin
         for (int i = 9; i >= 0; i--) begin
            fb = r[9] ^ d[i];
            r = {r[8:0], 1'b0} ^ (fb ? CRC10_POLY : 10'h000);
         end
      end
      return r;
   endfunction

   wire [9:0] seed = seed_one ? (mode8 ? CRC8_ONES : CRC10_ONES) : 10'h000;

   always_ff @(posedge clk) begin
      if (rst) begin
         crc <= 10'h000;
      end else if (init) begin
         crc <= seed;
      end else if (en) begin
         crc <= crc_step(crc, din, mode8);
      end
   end
endmodule

// ---- logic/sscrc_output.sv ----
// sscrc_output: sync channel, four data lanes and parallel port of the sensor output.
// assumes: kernels arrive on clk from array readout logic; pix_clk is the
// sensor pixel clock, asynchronous, much slower than clk; one word per lane per
// rising pix_clk edge.
`timescale 1ns/100ps

// Overview of operation
// - 8-bit: window id sits in bits 4:2
// - 8-bit: same overlapping-window choice as 10-bit
// - 8-bit: class codes are register bits 9:2
// - black pixels flagged with black code, default 0x05
// - image pixels flagged with image code, default 0x0D
// - check cycles 0x16, training 0xE9 defaults
// - idle: lanes send training, sync sends training code
// - lane training word is register 130, default 0x3A6
// - 8-bit lane training uses bits 9:2
// - line-end check covers only that line's data
// - sync sends check code when lanes send check
// - 10-bit polynomial x10+x9+x6+x3+x2+x+1
// - reseed each line, advance per data word
// - seed select: zeros or ones
// - 8-bit polynomial x8+x6+x3+x2+1, same seed
// - check spans the output line, not windows
// - kernels are 8x1, kernel 0 bottom left
// - no subsampling: two pixels per lane, sequential
// - even kernels ascending, odd kernels descending
// - mono subsampling: even positions of 16
// - color subsampling: pixels 0,1,4,5,8,9,12,13
// - parallel port: 10-bit, clock, frame/line valid, no ids
// - parallel port never runs 8-bit mode
// - 8-bit sync word: type 7:5, code bits 4:0
// - overlapping windows: highest window id wins
module sscrc_output (
   input wire logic clk, // system clock, 200 MHz
   input wire logic rst, // sync reset, active high
   input wire logic pix_clk, // sensor pixel clock, async
   input wire logic mode8, // 8-bit output mode
   input wire logic subsample, // subsampled readout
   input wire logic color, // color part
   input wire logic parallel_mode, // parallel port variant
   input wire logic crc_seed_one, // check seed select
   input wire logic [sscrc_pkg::WORD_W-1:0] kern_word, // kernel plus line flags
   input wire logic kern_valid, // kernel offered
   output logic kern_ready, // kernel taken when valid
   input wire logic [7:0] reg_addr, // register index
   input wire logic [9:0] reg_wdata, // register write data
   input wire logic reg_we, // register write strobe
   output logic [9:0] reg_rdata, // register read data
   output logic [9:0] sync_data, // sync channel word
   output logic [sscrc_pkg::LANES*10-1:0] lanes_data, // lane n at bits 10n+9:10n
   output logic [9:0] par_data, // parallel data word
   output logic par_clk, // parallel output clock
   output logic frame_valid, // parallel frame valid
   output logic line_valid // parallel line valid
);
   import sscrc_pkg::*;

   // pixel slot position within a 16-pixel span
   function automatic logic [3:0] seq_pos(logic [2:0] q, logic odd, logic sub, logic col);
      logic [3:0] p;
      p = {1'b0, q};
      if (sub && col) begin
         p = {q[2:1], 1'b0, q[0]};
      end else if (sub) begin
         p = {q, 1'b0};
      end else if (odd) begin
         p = 4'h7 - {1'b0, q};
      end
      return p;
   endfunction

   // 8-bit mode keeps the top eight bits, right-aligned
   function automatic logic [9:0] fit(logic [9:0] w, logic m8);
      return m8 ? {2'b00, w[9:2]} : w;
   endfunction

   function automatic logic [2:0] highest(logic [7:0] mask);
      logic [2:0] id;
      id = 3'd0;
      for (int i = 0; i < 8; i++) begin
         if (mask[i]) id = i[2:0];
      end
      return id;
   endfunction

   // pixel clock sampling; first stage feeds only the second
   logic pix_meta, pix_sync, pix_prev;
   wire slot_en = pix_sync & ~pix_prev;

   always_ff @(posedge clk) begin
      if (rst) begin
         pix_meta <= 1'b0;
         pix_sync <= 1'b0;
         pix_prev <= 1'b0;
      end else begin
         pix_meta <= pix_clk;
         pix_sync <= pix_meta;
         pix_prev <= pix_sync;
      end
   end

   // configuration registers
   logic [9:0] data_lane_training_word, frame_sync_code, black_class_code;
   logic [9:0] image_class_code, check_class_code, sync_training_class_code;

   always_ff @(posedge clk) begin
      if (rst) begin
         data_lane_training_word <= RST_TRAIN;
         frame_sync_code <= RST_SYNC;
         black_class_code <= RST_BLACK;
         image_class_code <= RST_IMAGE;
         check_class_code <= RST_CHECK;
         sync_training_class_code <= RST_STRAIN;
      end else if (reg_we) begin
         if (reg_addr == ADDR_TRAIN) data_lane_training_word <= reg_wdata;
         else if (reg_addr == ADDR_SYNC) frame_sync_code <= reg_wdata;
         else if (reg_addr == ADDR_BLACK) black_class_code <= reg_wdata;
         else if (reg_addr == ADDR_IMAGE) image_class_code <= reg_wdata;
         else if (reg_addr == ADDR_CHECK) check_class_code <= reg_wdata;
         else if (reg_addr == ADDR_STRAIN) sync_training_class_code <= reg_wdata;
      end
   end

   wire [9:0] rd_mux =
      (reg_addr == ADDR_TRAIN) ? data_lane_training_word :
      (reg_addr == ADDR_SYNC) ? frame_sync_code :
      (reg_addr == ADDR_BLACK) ? black_class_code :
      (reg_addr == ADDR_IMAGE) ? image_class_code :
      (reg_addr == ADDR_CHECK) ? check_class_code :
      (reg_addr == ADDR_STRAIN) ? sync_training_class_code : 10'h000;

   always_ff @(posedge clk) begin
      if (rst) reg_rdata <= 10'h000;
      else reg_rdata <= rd_mux;
   end

   // kernel buffer between array readout and the output slots
   logic [WORD_W-1:0] head;
   logic head_valid, pop;

   sscrc_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_data(kern_word),
      .in_valid(kern_valid),
      .in_ready(kern_ready),
      .out_data(head),
      .out_valid(head_valid),
      .out_ready(pop)
   );

   // output sequencer state
   sscrc_state_type state;
   logic [2:0] slot;
   logic have_a, odd_kern;
   logic [KERN_PIX*PIX_W-1:0] kern_a;
   logic line_black, line_fbeg, end_fend, in_frame;
   logic [2:0] line_win, end_win;

   wire m8 = mode8 & ~parallel_mode;
   wire [2:0] last_slot = parallel_mode ? 3'd7 : 3'd1;
   wire head_first = head[F_FIRST];
   wire head_last = head[F_LAST];
   wire [2:0] head_win = highest(head[F_WIN_LSB +: 8]);
   wire load_a = (state == ST_PIX) && subsample && !have_a && head_valid;
   wire data_ok = head_valid && (!subsample || have_a);
   wire emit = (state == ST_PIX) && data_ok;
   wire kern_done = slot_en && emit && (slot == last_slot);
   wire stray = (state == ST_IDLE) && slot_en && head_valid && !head_first;
   assign pop = load_a || kern_done || stray;

   // second kernel of a subsampled pair sits in the upper half
   wire [2*KERN_PIX*PIX_W-1:0] span = subsample ?
      {head[KERN_PIX*PIX_W-1:0], kern_a} : {{KERN_PIX*PIX_W{1'b0}}, head[KERN_PIX*PIX_W-1:0]};

   wire [9:0] lane_train = fit(data_lane_training_word, m8);
   wire [9:0] train_code = fit(sync_training_class_code, m8);
   wire [9:0] black_code = fit(black_class_code, m8);
   wire [9:0] image_code = fit(image_class_code, m8);
   wire [9:0] chk_code = fit(check_class_code, m8);
   wire [2:0] begin_type = line_fbeg ? frame_begin_mark : line_begin_mark;
   wire [2:0] end_type = end_fend ? frame_finish_mark : line_finish_mark;
   wire [9:0] begin_word = m8 ? {2'b00, begin_type, frame_sync_code[6:2]} :
      {begin_type, frame_sync_code[6:0]};
   wire [9:0] end_word = m8 ? {2'b00, end_type, frame_sync_code[6:2]} :
      {end_type, frame_sync_code[6:0]};
   wire [9:0] begin_id = m8 ? {5'b00000, line_win, 2'b00} : {7'b0000000, line_win};
   wire [9:0] end_id = m8 ? {5'b00000, end_win, 2'b00} : {7'b0000000, end_win};

   // pixel picked for each lane and for the parallel port this slot
   logic [LANES*10-1:0] lane_pix;
   logic [9:0] par_pix;
   logic [LANES*10-1:0] crc_all;

   always_comb begin
      logic [3:0] p;
      p = 4'h0;
      for (int c = 0; c < LANES; c++) begin
         // lane c carries kernel slots 2c and 2c+1 back to back
         p = seq_pos({c[1:0], slot[0]}, odd_kern, subsample, color);
         lane_pix[c*10 +: 10] = fit(span[p*PIX_W +: PIX_W], m8);
      end
      p = seq_pos(slot, odd_kern, subsample, color);
      par_pix = span[p*PIX_W +: PIX_W];
   end

   // next output words, chosen by sequencer state
   logic [9:0] next_sync;
   logic [LANES*10-1:0] next_lanes;

   always_comb begin
      next_sync = train_code;
      next_lanes = {LANES{lane_train}};
      case (state)
         ST_BEGIN_MARK: next_sync = begin_word;
         ST_BEGIN_ID: next_sync = begin_id;
         ST_END_MARK: next_sync = end_word;
         ST_END_ID: next_sync = end_id;
         ST_PIX: begin
            if (emit) begin
               next_sync = line_black ? black_code : image_code;
               next_lanes = lane_pix;
            end
         end
         ST_CHECK: begin
            next_sync = chk_code;
            next_lanes = crc_all;
         end
         default: ;
      endcase
   end

   // one check generator per lane; lane 0 also serves the parallel port
   wire crc_init = slot_en && (state == ST_BEGIN_ID);
   wire crc_en = slot_en && emit;

   for (genvar c = 0; c < LANES; c++) begin : g_crc
      wire [9:0] crc_in = (parallel_mode && c == 0) ? par_pix : lane_pix[c*10 +: 10];
      sscrc_crc u_crc (
         .clk(clk),
         .rst(rst),
         .init(crc_init),
         .en(crc_en),
         .seed_one(crc_seed_one),
         .mode8(m8),
         .din(crc_in),
         .crc(crc_all[c*10 +: 10])
      );
   end

   // sequencer: one step per pixel slot; subsampled pairs load between slots
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_IDLE;
         slot <= 3'd0;
         have_a <= 1'b0;
         odd_kern <= 1'b0;
         kern_a <= '0;
         line_black <= 1'b0;
         line_fbeg <= 1'b0;
         line_win <= 3'd0;
         end_fend <= 1'b0;
         end_win <= 3'd0;
      end else begin
         if (load_a) begin
            kern_a <= head[KERN_PIX*PIX_W-1:0];
            have_a <= 1'b1;
         end
         if (slot_en) begin
            case (state)
               ST_IDLE: begin
                  if (head_valid && head_first) begin
                     // check restarts per output line whatever windows share it
                     line_black <= head[F_BLACK];
                     line_fbeg <= head[F_FBEG];
                     line_win <= head_win;
                     state <= ST_BEGIN_MARK;
                  end
               end
               ST_BEGIN_MARK: state <= ST_BEGIN_ID;
               ST_BEGIN_ID: begin
                  slot <= 3'd0;
                  odd_kern <= 1'b0;
                  state <= ST_PIX;
               end
               ST_PIX: begin
                  if (emit) begin
                     slot <= (slot == last_slot) ? 3'd0 : slot + 3'd1;
                     if (slot == last_slot) begin
                        have_a <= 1'b0;
                        odd_kern <= ~odd_kern;
                        if (head_last) begin
                           end_fend <= head[F_FEND];
                           end_win <= head_win;
                           state <= ST_END_MARK;
                        end
                     end
                  end
               end
               ST_END_MARK: state <= ST_END_ID;
               ST_END_ID: state <= ST_CHECK;
               ST_CHECK: state <= ST_IDLE;
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // output registers, refreshed once per pixel slot
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_data <= 10'h000;
         lanes_data <= '0;
         par_data <= 10'h000;
         line_valid <= 1'b0;
         frame_valid <= 1'b0;
         in_frame <= 1'b0;
      end else if (slot_en) begin
         sync_data <= parallel_mode ? 10'h000 : next_sync;
         lanes_data <= parallel_mode ? '0 : next_lanes;
         // parallel port: pixel while line valid, check word in the third slot after the last pixel
         par_data <= emit ? par_pix : (state == ST_CHECK) ? crc_all[9:0] :
            data_lane_training_word;
         line_valid <= parallel_mode && emit;
         if (state == ST_BEGIN_ID && line_fbeg) in_frame <= 1'b1;
         else if (state == ST_CHECK && end_fend) in_frame <= 1'b0;
         frame_valid <= parallel_mode && (in_frame || (state == ST_BEGIN_ID && line_fbeg));
      end
   end

   // output clock follows the sampled pixel clock, rising one clock after the data changes
   always_ff @(posedge clk) begin
      if (rst) par_clk <= 1'b0;
      else par_clk <= pix_prev & parallel_mode;
   end

endmodule

// ---- dv/sscrc_output_checker.sv ----
// sscrc_output_checker: port-level properties of the sync/check output block.
// assumes: training registers keep reset values; bound below.
`timescale 1ns/100ps
module sscrc_output_checker (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset
   input wire logic pix_clk, // pixel clock
   input wire logic mode8, // 8-bit mode
   input wire logic kern_valid, // kernel offered
   input wire logic kern_ready, // fifo room
   input wire logic [7:0] reg_addr, // register index
   input wire logic [9:0] reg_rdata, // register read data
   input wire logic [9:0] sync_data, // sync word
   input wire logic [39:0] lanes_data // lane words
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // words move just after a pixel clock rise
   a_word_settled: assert property (
      !pix_clk && !$past(pix_clk) && !$past(pix_clk, 2) |-> $stable(sync_data) && $stable(lanes_data))
      else $error("sync or lane word moved late in the pixel clock period");
   a_id_bits8: assert property (
      mode8 && $changed(sync_data) && $past(sync_data[9:8]) == 2'b00 &&
      $past(sync_data[4:0]) == 5'h0a && $past(sync_data[7:5]) inside {3'h1, 3'h2, 3'h5, 3'h6}
      |-> sync_data[9:5] == 5'h00 && sync_data[1:0] == 2'b00)
      else $error("window id word after a mark has stray bits");
   a_idle_train10: assert property (
      !mode8 && sync_data == 10'h3a6 |-> lanes_data == {4{10'h3a6}})
      else $error("lanes not training while sync sends training code");
   a_idle_train8: assert property (
      mode8 && sync_data == 10'h0e9 |-> lanes_data == {4{10'h0e9}})
      else $error("8-bit lanes not training while sync sends training code");
   a_full_after_store: assert property ($fell(kern_ready) |-> $past(kern_valid))
      else $error("kernel ready fell without a kernel stored");
   a_ready_release: assert property ($fell(rst) |-> !kern_ready ##1 kern_ready)
      else $error("kernel ready not raised at first edge after reset");
   a_unmapped_zero: assert property (
      $stable(reg_addr) && !(reg_addr inside {[8'h82:8'h87]}) |=> reg_rdata == 10'h000)
      else $error("unmapped register index read nonzero");
   a_train_readback: assert property (
      $stable(reg_addr) && reg_addr == 8'h82 |=> reg_rdata == 10'h3a6)
      else $error("lane training register read wrong");
endmodule
bind sscrc_output sscrc_output_checker i_sscrc_output_checker (.clk(clk), .rst(rst),
   .pix_clk(pix_clk), .mode8(mode8), .kern_valid(kern_valid), .kern_ready(kern_ready),
   .reg_addr(reg_addr), .reg_rdata(reg_rdata), .sync_data(sync_data), .lanes_data(lanes_data));

// ---- dv/sscrc_rx_model.sv ----
// sscrc_rx_model: receiving side, collects one sync word and four lane words per slot.
// assumes: words settle within a few system clocks after each pixel clock rise.
`timescale 1ns/100ps
module sscrc_rx_model (
   input wire logic pix_clk, // sensor pixel clock
   input wire logic [9:0] sync_data, // sync channel word
   input wire logic [39:0] lanes_data // four lane words
);
   logic [49:0] slots[$];
   // mid-period sample, words long settled
   always @(negedge pix_clk) slots.push_back({sync_data, lanes_data});
endmodule

// ---- dv/sensor_sync_crc_output_test.sv ----
// sensor_sync_crc_output_test: register, idle, line framing, check and ordering tests.
// assumes: sscrc_output with checker bound; parallel port left off.
`timescale 1ns/100ps
module sensor_sync_crc_output_test;
   import sscrc_pkg::*;
   logic clk = 0, rst = 1, pix_clk = 0, pix_run = 1;
   logic mode8 = 0, subsample = 0, color = 0, crc_seed_one = 0, kern_valid = 0, reg_we = 0;
   logic [WORD_W-1:0] kern_word = '0;
   logic [7:0] reg_addr = 8'h00;
   logic [9:0] reg_wdata = 10'h000, reg_rdata, sync_data, par_data, ss;
   logic [39:0] lanes_data, sl;
   logic kern_ready, par_clk, frame_valid, line_valid;
   int error_cnt = 0, checks_done = 0;
   always #2.5 clk = ~clk;
   always begin
      #24;
      if (pix_run) pix_clk = ~pix_clk;
   end
   sscrc_output i_sscrc_output (.clk(clk), .rst(rst), .pix_clk(pix_clk), .mode8(mode8),
      .subsample(subsample), .color(color), .parallel_mode(1'b0), .crc_seed_one(crc_seed_one),
      .kern_word(kern_word), .kern_valid(kern_valid), .kern_ready(kern_ready),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
      .sync_data(sync_data), .lanes_data(lanes_data), .par_data(par_data), .par_clk(par_clk),
      .frame_valid(frame_valid), .line_valid(line_valid));
   sscrc_rx_model i_sscrc_rx_model (.pix_clk(pix_clk), .sync_data(sync_data),
      .lanes_data(lanes_data));
   task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [9:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [9:0] exp);
      @(posedge clk);
      reg_addr <= a;
      repeat (2) @(posedge clk);
      #1 cmp("reg_rdata", exp, reg_rdata);
   endtask
   task automatic next_slot;
      int n;
      n = 0;
      while (i_sscrc_rx_model.slots.size() == 0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      if (n == 400) begin
         error_cnt++;
         $display("CHECK FAILED slot expected word seen none");
         close_out();
      end
      {ss, sl} = i_sscrc_rx_model.slots.pop_front();
   endtask
   task automatic push(input logic [WORD_W-1:0] w);
      int n;
      n = 0;
      @(posedge clk);
      kern_word <= w;
      kern_valid <= 1'b1;
      #1;
      while (kern_ready !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 400) begin
         error_cnt++;
         $display("CHECK FAILED kern_ready expected 1 seen 0");
         close_out();
      end
      @(posedge clk);
      kern_valid <= 1'b0;
   endtask
   task automatic set_mode(input logic m8, input logic sd, input logic sb, input logic cl);
      @(posedge clk);
      mode8 <= m8;
      crc_seed_one <= sd;
      subsample <= sb;
      color <= cl;
      repeat (40) @(posedge clk);
      i_sscrc_rx_model.slots.delete();
   endtask
   function automatic logic [9:0] pv(int l, int k, int i);
      return 10'((l * 211 + k * 97 + i * 29 + 5) % 1024);
   endfunction
   function automatic logic [9:0] code(logic [9:0] v);
      return mode8 ? {2'b00, v[9:2]} : v;
   endfunction
   function automatic logic [9:0] mk(logic [2:0] t);
      return mode8 ? {2'b00, t, RST_SYNC[6:2]} : {t, RST_SYNC[6:0]};
   endfunction
   // msb first, no reflection, no final xor
   function automatic logic [9:0] crc_f(logic [9:0] c, logic [9:0] d);
      logic fb;
      for (int i = 9; i >= 0; i--) begin
         fb = mode8 ? c[7] ^ d[i] : c[9] ^ d[i];
         if (mode8 && i < 8) c = {2'b00, c[6:0], 1'b0} ^ {2'b00, fb ? CRC8_POLY : 8'h00};
         else if (!mode8) c = {c[8:0], 1'b0} ^ (fb ? CRC10_POLY : 10'h000);
      end
      return c;
   endfunction
   task automatic send(int l, int nk, logic ff, logic lf, logic blk, logic [7:0] m);
      logic [WORD_W-1:0] w;
      for (int k = 0; k < nk; k++) begin
         w = '0;
         for (int i = 0; i < 8; i++) w[10*i +: 10] = pv(l, k, i);
         w[F_FIRST] = (k == 0);
         w[F_LAST] = (k == nk - 1);
         w[F_FBEG] = ff;
         w[F_FEND] = lf;
         w[F_BLACK] = blk;
         w[F_WIN_LSB +: 8] = m;
         push(w);
      end
   endtask
   task automatic chk(int l, int nk, int sub, logic ff, logic lf, logic blk, logic [7:0] m);
      logic [9:0] crc[4];
      logic [9:0] w;
      int id, p, q, n;
      id = 0;
      n = 0;
      for (int b = 0; b < 8; b++) if (m[b]) id = b;
      for (int c = 0; c < 4; c++) crc[c] = crc_seed_one ? code(CRC10_ONES) : '0;
      next_slot();
      while (ss === code(RST_STRAIN) && n < 50) begin
         next_slot();
         n++;
      end
      cmp("begin mark", mk(ff ? frame_begin_mark : line_begin_mark), ss);
      next_slot();
      cmp("window id", mode8 ? 10'(id * 4) : 10'(id), ss);
      for (int j = 0; j < (sub > 0 ? nk / 2 : nk); j++) begin
         for (int t = 0; t < 2; t++) begin
            next_slot();
            cmp("class code", code(blk ? RST_BLACK : RST_IMAGE), ss);
            for (int c = 0; c < 4; c++) begin
               q = 2 * c + t;
               if (sub == 0) p = 8 * j + (j % 2 ? 7 - q : q);
               else if (sub == 1) p = 16 * j + 2 * q;
               else p = 16 * j + 4 * (q / 2) + q % 2;
               w = pv(l, p / 8, p % 8);
               if (mode8) w = {2'b00, w[9:2]};
               cmp("lane word", w, sl[10*c +: 10]);
               crc[c] = crc_f(crc[c], w);
            end
         end
      end
      next_slot();
      cmp("end mark", mk(lf ? frame_finish_mark : line_finish_mark), ss);
      next_slot();
      cmp("window id", mode8 ? 10'(id * 4) : 10'(id), ss);
      next_slot();
      cmp("check code", code(RST_CHECK), ss);
      for (int c = 0; c < 4; c++) cmp("lane check", crc[c], sl[10*c +: 10]);
   endtask
   initial begin
      logic [9:0] rv[6];
      rv = '{RST_TRAIN, RST_SYNC, RST_BLACK, RST_IMAGE, RST_CHECK, RST_STRAIN};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 6; a++) rd(ADDR_TRAIN + 8'(a), rv[a]);
      wr(ADDR_BLACK, 10'h2c4);
      rd(ADDR_BLACK, 10'h2c4);
      wr(8'h80, 10'h155);
      rd(8'h80, 10'h000);
      wr(ADDR_BLACK, RST_BLACK);
      $display("test registers done");
      set_mode(0, 0, 0, 0);
      next_slot();
      cmp("idle sync", RST_STRAIN, ss);
      for (int c = 0; c < 4; c++) cmp("idle lane", RST_TRAIN, sl[10*c +: 10]);
      send(1, 2, 1, 0, 0, 8'h24);
      chk(1, 2, 0, 1, 0, 0, 8'h24);
      send(2, 3, 0, 1, 0, 8'h01);
      chk(2, 3, 0, 0, 1, 0, 8'h01);
      $display("test ten bit lines done");
      set_mode(1, 1, 0, 0);
      next_slot();
      cmp("idle sync", 10'h0e9, ss);
      for (int c = 0; c < 4; c++) cmp("idle lane", 10'h0e9, sl[10*c +: 10]);
      send(3, 2, 0, 0, 1, 8'h81);
      chk(3, 2, 0, 0, 0, 1, 8'h81);
      $display("test eight bit line done");
      set_mode(0, 0, 1, 0);
      @(negedge pix_clk);
      pix_run = 0;
      for (int l = 4; l < 8; l++) send(l, 2, 0, 0, 0, 8'h02);
      @(posedge clk);
      #1 cmp("kern_ready full", 10'h000, {9'h000, kern_ready});
      pix_run = 1;
      for (int l = 4; l < 8; l++) chk(l, 2, 1, 0, 0, 0, 8'h02);
      set_mode(0, 0, 1, 1);
      send(8, 4, 0, 0, 0, 8'h02);
      chk(8, 4, 2, 0, 0, 0, 8'h02);
      $display("test subsample lines done");
      close_out();
   end
endmodule
